// *** swr_pkg.sv ***
package swr_pkg;
   // time base
   localparam int unsigned CLK_FREQ_HZ = 200_000_000;
   localparam longint unsigned RESET_PULSE_TIME_MS = 200;
   localparam longint unsigned WATCHDOG_TIMEOUT_TIME_MS = 1600;
   localparam longint unsigned RESET_PULSE_MIN_MS = 120;
   localparam longint unsigned RESET_PULSE_MAX_MS = 300;
   localparam longint unsigned WATCHDOG_MIN_MS = 1100;
   localparam longint unsigned WATCHDOG_MAX_MS = 2400;
   localparam longint unsigned RESET_PULSE_CYC =
      (RESET_PULSE_TIME_MS * CLK_FREQ_HZ) / 1000;
   localparam longint unsigned WATCHDOG_TIMEOUT_CYC =
      (WATCHDOG_TIMEOUT_TIME_MS * CLK_FREQ_HZ) / 1000;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned SYNC_STAGES = 3;

   // synchronised view of the four external inputs
   typedef struct packed {
      logic supply_low;
      logic manual_reset_low;
      logic kick;
      logic kick_undriven;
   } swr_in_t;

   // synchroniser reset value: supply taken as low, so power-up gives a full pulse
   localparam swr_in_t SWR_IN_RST = '{supply_low:       1'b1,
                                      manual_reset_low: 1'b0,
                                      kick:             1'b0,
                                      kick_undriven:    1'b0};

   typedef enum logic [1:0] {
      SWR_HOLD    = 2'b00,
      SWR_STRETCH = 2'b01,
      SWR_RUN     = 2'b10
   } swr_state_t;
endpackage : swr_pkg

// *** swr_supervisor.sv ***
// Operation
// - reset output held low while supply low or manual reset input low
// - reset pulse of 200 ms after supply recovery, expiry or manual release
// - kick input stuck at one level beyond 1.6 s timeout starts reset pulse
// - watchdog timer stays cleared while reset output is asserted
// - every kick edge clears the timer; processor must toggle within timeout
// - undriven kick input disables watchdog expiry entirely
// - reset pulse duration stays within 120 to 300 ms
// - watchdog timeout stays within 1.1 to 2.4 s
module swr_supervisor
   import swr_pkg::*;
#(
   parameter logic [CNT_W-1:0] RESET_PULSE_CYCLES = CNT_W'(RESET_PULSE_CYC),
   parameter logic [CNT_W-1:0] WATCHDOG_CYCLES    = CNT_W'(WATCHDOG_TIMEOUT_CYC)
) (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_supply_low,
   input  wire logic i_manual_reset_low_in,
   input  wire logic i_watchdog_kick_in,
   input  wire logic i_kick_undriven,
   output logic      o_sys_reset_low_out,
   output logic      o_watchdog_expired
);

   // refuse counts the counters cannot serve: below 2 the first counted
   // cycle and the terminal one would coincide
   if (RESET_PULSE_CYCLES < 32'h2 || WATCHDOG_CYCLES < 32'h2) begin : g_bad_counts
      $error("swr_supervisor: terminal counts must be at least 2");
   end

   // last count value of each timer, kept at the counter width
   localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(32'h1);
   localparam logic [CNT_W-1:0] PULSE_LAST = RESET_PULSE_CYCLES - CNT_ONE;
   localparam logic [CNT_W-1:0] WD_LAST    = WATCHDOG_CYCLES - CNT_ONE;

   // three-stage synchronisers; stage 1 feeds stage 2 only
   swr_in_t s1_reg, s2_reg, s3_reg;
   swr_in_t s1_next, s2_next, s3_next;
   swr_in_t pin_now;
   swr_in_t filt_reg, filt_next;
   logic [$bits(swr_in_t)-1:0] filt_bits;

   // per-bit agreement filter; one clock of disagreement keeps the old level,
   // which also swallows a glitch that lands between two samples
   for (genvar b = 0; b < $bits(swr_in_t); b = b + 1) begin : g_filt
      assign filt_bits[b] = (s2_reg[b] == s3_reg[b]) ? s3_reg[b] : filt_reg[b];
   end

   always_comb begin
      pin_now = '{supply_low:       i_supply_low,
                  manual_reset_low: ~i_manual_reset_low_in,
                  kick:             i_watchdog_kick_in,
                  kick_undriven:    i_kick_undriven};
      s1_next = pin_now;
      s2_next = s1_reg;
      s3_next = s2_reg;
      // a change counts only once stages 2 and 3 agree
      filt_next = swr_in_t'(filt_bits);
   end

   // reset value treats the supply as low, so power-up gives a full pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         s1_reg   <= SWR_IN_RST;
         s2_reg   <= SWR_IN_RST;
         s3_reg   <= SWR_IN_RST;
         filt_reg <= SWR_IN_RST;
      end else begin
         s1_reg   <= s1_next;
         s2_reg   <= s2_next;
         s3_reg   <= s3_next;
         filt_reg <= filt_next;
      end
   end

   // supervisor state, pulse counter and watchdog counter
   swr_state_t       state_reg, state_next;
   logic [CNT_W-1:0] pulse_cnt_reg, pulse_cnt_next;
   logic [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
   logic             kick_prev_reg, kick_prev_next;
   logic             expired_reg, expired_next;
   logic             rst_out_reg, rst_out_next;
   logic             hold_cond;
   logic             kick_edge;

   always_comb begin
      hold_cond      = filt_reg.supply_low | filt_reg.manual_reset_low;
      kick_edge      = filt_reg.kick ^ kick_prev_reg;
      kick_prev_next = filt_reg.kick;
      state_next     = state_reg;
      pulse_cnt_next = pulse_cnt_reg;
      wd_cnt_next    = wd_cnt_reg;
      expired_next   = 1'b0;
      unique case (state_reg)
         SWR_HOLD: begin
            // any holding cause keeps the pulse from starting
            pulse_cnt_next = '0;
            wd_cnt_next    = '0;
            if (!hold_cond)
               state_next = SWR_STRETCH;
         end
         SWR_STRETCH: begin
            wd_cnt_next = '0;
            if (hold_cond) begin
               state_next = SWR_HOLD;
            end else if (pulse_cnt_reg == PULSE_LAST) begin
               state_next     = SWR_RUN;
               pulse_cnt_next = '0;
            end else begin
               pulse_cnt_next = pulse_cnt_reg + CNT_ONE;
            end
         end
         SWR_RUN: begin
            pulse_cnt_next = '0;
            if (hold_cond) begin
               state_next  = SWR_HOLD;
               wd_cnt_next = '0;
            end else if (kick_edge || filt_reg.kick_undriven) begin
               wd_cnt_next = '0;
            end else if (wd_cnt_reg == WD_LAST) begin
               // expiry restarts the stretch just like a released hold
               state_next   = SWR_STRETCH;
               wd_cnt_next  = '0;
               expired_next = 1'b1;
            end else begin
               wd_cnt_next = wd_cnt_reg + CNT_ONE;
            end
         end
         default: begin
            state_next     = SWR_HOLD;
            pulse_cnt_next = '0;
            wd_cnt_next    = '0;
         end
      endcase
      // output follows the state being entered, so output and state flop agree
      rst_out_next = (state_next == SWR_RUN);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_reg     <= SWR_HOLD;
         pulse_cnt_reg <= '0;
         wd_cnt_reg    <= '0;
         kick_prev_reg <= 1'b0;
         expired_reg   <= 1'b0;
         rst_out_reg   <= 1'b0;
      end else begin
         state_reg     <= state_next;
         pulse_cnt_reg <= pulse_cnt_next;
         wd_cnt_reg    <= wd_cnt_next;
         kick_prev_reg <= kick_prev_next;
         expired_reg   <= expired_next;
         rst_out_reg   <= rst_out_next;
      end
   end

   // reset output straight from a flop: no decode glitch reaches the processor
   assign o_sys_reset_low_out = rst_out_reg;
   assign o_watchdog_expired  = expired_reg;

   // checks
   a_hold_forces_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      hold_cond |=> !o_sys_reset_low_out)
      else $error("reset output released while hold cause present");

   a_pulse_width: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_sys_reset_low_out) |-> $past(state_reg == SWR_STRETCH)
         && $past(pulse_cnt_reg) == PULSE_LAST)
      else $error("reset released before full pulse");

   a_stretch_after_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_reg == SWR_HOLD && !hold_cond) |=> state_reg == SWR_STRETCH)
      else $error("pulse did not start after hold ended");

   a_expiry_starts_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      expired_reg |-> state_reg == SWR_STRETCH && !o_sys_reset_low_out)
      else $error("expiry did not start a reset pulse");

   a_wd_clear_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      state_reg != SWR_RUN |-> wd_cnt_reg == '0)
      else $error("watchdog counting during reset");

   a_kick_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_reg == SWR_RUN && kick_edge) |=> wd_cnt_reg == '0)
      else $error("kick edge did not clear watchdog");

   a_undriven_no_expiry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      filt_reg.kick_undriven |=> !expired_reg)
      else $error("expiry while kick input undriven");

   a_counts_bounded: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      pulse_cnt_reg < RESET_PULSE_CYCLES && wd_cnt_reg < WATCHDOG_CYCLES)
      else $error("counter beyond terminal count");

   a_out_tracks_run: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_sys_reset_low_out == (state_reg == SWR_RUN))
      else $error("reset output disagrees with supervisor state");

   a_pulse_counts_up: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_reg == SWR_STRETCH && !hold_cond && pulse_cnt_reg != PULSE_LAST)
         |=> state_reg == SWR_STRETCH && pulse_cnt_reg == $past(pulse_cnt_reg) + CNT_ONE)
      else $error("reset pulse counter skipped or stalled");

   a_stuck_kick_expires: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_reg == SWR_RUN && !hold_cond && !kick_edge && !filt_reg.kick_undriven
         && wd_cnt_reg == WD_LAST) |=> expired_reg && !o_sys_reset_low_out)
      else $error("stuck kick input did not expire the watchdog");

   a_wd_counts_run: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_reg == SWR_RUN && !hold_cond && !kick_edge && !filt_reg.kick_undriven
         && wd_cnt_reg != WD_LAST) |=> wd_cnt_reg == $past(wd_cnt_reg) + CNT_ONE)
      else $error("watchdog timer skipped or stalled");

   a_expiry_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      expired_reg |=> !expired_reg)
      else $error("expiry flag stood longer than one cycle");

endmodule // swr_supervisor

// *** swr_cpu_model.sv ***
// supervised processor: toggles the kick input while it runs
module swr_cpu_model (
   input  wire logic i_clk,
   input  wire logic i_sys_reset_low_out,
   input  wire logic i_kick_en,
   output logic      o_watchdog_kick_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg;
   initial o_watchdog_kick_in = 1'b0;
   initial cnt_reg = 8'h00;
   // a 30-cycle level is far above the minimum hold and well inside the timeout
   always @(posedge i_clk) begin
      if (!i_sys_reset_low_out || !i_kick_en) begin
         cnt_reg <= 8'h00;
      end else if (cnt_reg == 8'h1d) begin
         cnt_reg <= 8'h00;
         o_watchdog_kick_in <= ~o_watchdog_kick_in;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule // swr_cpu_model

// *** supervisor_watchdog_reset_test.sv ***
module supervisor_watchdog_reset_test
   import swr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [CNT_W-1:0] PULSE = 32'h14;
   localparam logic [CNT_W-1:0] WD    = 32'h64;
   logic clk = 1'b0, rst_b = 1'b0, supply_low = 1'b0, undriven = 1'b0;
   logic manual_reset_low = 1'b1;
   logic kick_en = 1'b0;
   wire  kick, sys_reset_low, expired;
   int   errors = 0, comparisons = 0, cycles = 0, exp_cnt = 0, n;
   swr_supervisor #(.RESET_PULSE_CYCLES(PULSE), .WATCHDOG_CYCLES(WD)) DUT (
      .i_clk(clk), .i_rst_b(rst_b), .i_supply_low(supply_low),
      .i_manual_reset_low_in(manual_reset_low), .i_watchdog_kick_in(kick),
      .i_kick_undriven(undriven), .o_sys_reset_low_out(sys_reset_low),
      .o_watchdog_expired(expired));
   swr_cpu_model cpu (.i_clk(clk), .i_sys_reset_low_out(sys_reset_low),
      .i_kick_en(kick_en), .o_watchdog_kick_in(kick));
   initial forever #2.5 clk = ~clk;
   // hang guard, well above the fewer than 1500 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (expired === 1'b1) exp_cnt++;
      if (cycles == 20000) begin
         errors++;
         finish_test();
      end
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // counts edges until reset output reaches lvl, bounded
   task automatic wait_level(logic lvl);
      n = 0;
      while (sys_reset_low !== lvl && n < 1000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic hold_test(bit use_supply);
      @(posedge clk);
      if (use_supply) supply_low <= 1'b1;
      else manual_reset_low <= 1'b0;
      repeat (60) @(posedge clk);
      check("held_low", sys_reset_low, 0);
      if (use_supply) supply_low <= 1'b0;
      else manual_reset_low <= 1'b1;
      wait_level(1'b1);
      check("pulse_after_hold", n >= PULSE && n <= PULSE + 8, 1);
   endtask
   task automatic watchdog_test();
      kick_en <= 1'b1;
      repeat (400) @(posedge clk);
      check("kicked_no_reset", {sys_reset_low, exp_cnt[0]}, 2'h2);
      kick_en <= 1'b0;
      wait_level(1'b0);
      check("expiry_time", n >= WD - 32 && n <= WD + 8, 1);
      wait_level(1'b1);
      check("pulse_after_expiry", n >= PULSE && n <= PULSE + 8, 1);
      // the monitor bumps the count at the very edge the level wait ends on,
      // so the count is read only once the pulse is over
      check("expiry_count", exp_cnt, 1);
      // timer was held clear during the pulse, so a full timeout follows
      wait_level(1'b0);
      check("timer_restart", n >= WD - 1 && n <= WD + 8, 1);
   endtask
   task automatic undriven_test();
      undriven <= 1'b1;
      wait_level(1'b1);
      n = exp_cnt;
      repeat (400) @(posedge clk);
      check("undriven_quiet", {sys_reset_low, exp_cnt == n}, 2'h3);
      undriven <= 1'b0;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wait_level(1'b1);
      check("power_on_pulse", n >= PULSE && n <= PULSE + 10, 1);
      hold_test(1'b0);
      hold_test(1'b1);
      watchdog_test();
      undriven_test();
      finish_test();
   end
endmodule // supervisor_watchdog_reset_test
